// [core/dtvc_coder.sv]
`timescale 1ns/1ps
`default_nettype none
// ======================================================
// value packet coder: element requests in, trace bytes out
module dtvc_coder (
  input wire logic sys_clk, // 100 MHz clock
  input wire logic srst, // sync reset, active high
  // element request group
  input wire logic reqValid, // request offered
  output logic reqReady, // one-cycle pulse after the request was taken on the previous edge
  input wire logic [1:0] reqKind, // 0 single value,1 pair,2 event,3 pad
  input wire logic [63:0] reqValue0, // first value
  input wire logic [31:0] reqValue1, // second value (pair)
  input wire logic reqWide, // first value needs 64 bits
  input wire logic [2:0] reqAddrCount, // untraced address elements 0..4
  input wire logic [1:0] reqKeyAdvance, // first key advance 1..3
  // trace byte stream
  output logic traceValid, // byte available
  input wire logic traceReady, // sink accepts
  output logic [7:0] traceData, // byte
  // avalon-mm slave
  input wire logic [3:0] avsAddress, // byte address
  input wire logic avsRead, // read strobe
  input wire logic avsWrite, // write strobe
  input wire logic [31:0] avsWriteData, // write data
  input wire logic [3:0] avsByteEnable, // byte lanes
  output logic [31:0] avsReadData, // read data
  output logic avsWaitRequest, // stall
  output logic avsReadDataValid, // read data strobe
  output logic avsResponse // 1 = unmapped access
);
  // ======================================================
  // packet assembly
  dtvc_pkg::dtvc_state_t state_q;
  logic [7:0] buf_q [9];
  logic [3:0] len_q;
  logic [3:0] idx_q;
  logic [31:0] ctrl_q;
  logic [31:0] pktCount_q;
  logic [31:0] errCount_q;
  logic lastErr_q;
  logic fifoInReady;
  logic fifoOutValid;
  logic [7:0] fifoOutData;
  logic pushValid;
  logic take;
  logic usePair;
  logic [2:0] keyCode;
  logic keyBad;
  logic enable;
  assign enable = ctrl_q[0];

  // key code: advance 1 with 0..4 elements, then +2, +3; 111 reserved
  function automatic logic [2:0] keyCodeOf(input logic [1:0] adv,
                                           input logic [2:0] cnt);
    if (adv == 2'h1 && cnt <= 3'h4) begin
      return cnt;
    end else if (adv == 2'h2 && cnt == 3'h0) begin
      return 3'h5;
    end else if (adv == 2'h3 && cnt == 3'h0) begin
      return 3'h6;
    end else begin
      return dtvc_pkg::KEY_CODE_RESERVED;
    end
  endfunction

  assign keyCode = keyCodeOf(reqKeyAdvance, reqAddrCount);
  assign keyBad = (keyCode == dtvc_pkg::KEY_CODE_RESERVED);
  // pair format needs two 32-bit values and an encodable code; the
  // second key is implicitly first plus one, so the source must supply
  // adjacent keys for a pair
  assign usePair = (reqKind == 2'h1) && !reqWide && !keyBad;
  // requests are taken only when idle so one packet is built at a time
  assign take = reqValid && (state_q == dtvc_pkg::ST_IDLE) && enable;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      reqReady <= 1'b0;
    end else begin
      reqReady <= 1'b0;
      if (take && !reqReady) begin
        reqReady <= 1'b1;
      end
    end
  end

  // build packet image, then stream it byte by byte into the fifo
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_q <= dtvc_pkg::ST_IDLE;
      len_q <= '0;
      idx_q <= '0;
      lastErr_q <= 1'b0;
      for (int i = 0; i < 9; i++) begin
        buf_q[i] <= 8'h00;
      end
    end else begin
      case (state_q)
        dtvc_pkg::ST_IDLE: begin
          if (take && !reqReady) begin
            idx_q <= '0;
            lastErr_q <= 1'b0;
            state_q <= dtvc_pkg::ST_DATA;
            case (reqKind)
              2'h2: begin
                buf_q[0] <= dtvc_pkg::EVENT_BYTE;
                len_q <= 4'h1;
              end
              2'h3: begin
                buf_q[0] <= dtvc_pkg::IGNORE_BYTE;
                len_q <= 4'h1;
              end
              default: begin
                if (usePair) begin
                  buf_q[0] <= {dtvc_pkg::F6_HDR_TOP, keyCode};
                  for (int i = 0; i < 4; i++) begin
                    buf_q[1+i] <= reqValue0[8*i +: 8];
                    buf_q[5+i] <= reqValue1[8*i +: 8];
                  end
                  len_q <= 4'h9;
                end else if (reqAddrCount >= 3'h1 &&
                             reqAddrCount <= 3'h4) begin
                  // single value, count field is elements minus one
                  buf_q[0] <= {dtvc_pkg::F5_HDR_TOP, reqWide,
                               2'(reqAddrCount - 3'h1)};
                  for (int i = 0; i < 8; i++) begin
                    buf_q[1+i] <= reqValue0[8*i +: 8];
                  end
                  len_q <= reqWide ? 4'h9 : 4'h5;
                end else begin
                  // nothing encodable in these formats: drop and count
                  lastErr_q <= 1'b1;
                  state_q <= dtvc_pkg::ST_IDLE;
                end
              end
            endcase
          end
        end
        dtvc_pkg::ST_DATA: begin
          if (pushValid && fifoInReady) begin
            idx_q <= idx_q + 4'h1;
            if (idx_q + 4'h1 == len_q) begin
              state_q <= dtvc_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          state_q <= dtvc_pkg::ST_IDLE;
        end
      endcase
    end
  end
  assign pushValid = (state_q == dtvc_pkg::ST_DATA);

  dtvc_fifo #(
    .WIDTH(dtvc_pkg::FIFO_WIDTH),
    .DEPTH(dtvc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .srst(srst),
    .inValid(pushValid),
    .inReady(fifoInReady),
    .inData(buf_q[idx_q]),
    .outValid(fifoOutValid),
    .outReady(!traceValid || traceReady),
    .outData(fifoOutData)
  );

  // registered output stage so the byte stream comes from flops
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      traceValid <= 1'b0;
      traceData <= 8'h00;
    end else if (!traceValid || traceReady) begin
      traceValid <= fifoOutValid;
      traceData <= fifoOutData;
    end
  end

  // ======================================================
  // statistics
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pktCount_q <= '0;
      errCount_q <= '0;
    end else begin
      if (state_q == dtvc_pkg::ST_DATA && pushValid && fifoInReady &&
          idx_q + 4'h1 == len_q) begin
        pktCount_q <= pktCount_q + 32'h1;
      end
      if (state_q == dtvc_pkg::ST_IDLE && take && !reqReady &&
          (reqKind == 2'h0 || reqKind == 2'h1) && !usePair &&
          (reqAddrCount == 3'h0 || reqAddrCount > 3'h4)) begin
        errCount_q <= errCount_q + 32'h1;
      end
    end
  end

  // ======================================================
  // avalon-mm slave: one wait cycle, then answer; a write lands only on
  // the edge that sees waitrequest low, so the master's view and ours agree
  logic busy_q;
  logic hit;
  always_comb begin
    hit = (32'(avsAddress) == dtvc_pkg::CSR_CTRL) ||
          (32'(avsAddress) == dtvc_pkg::CSR_STATUS) ||
          (32'(avsAddress) == dtvc_pkg::CSR_COUNT);
  end
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      busy_q <= 1'b0;
      avsWaitRequest <= 1'b1;
      avsReadData <= '0;
      avsReadDataValid <= 1'b0;
      avsResponse <= 1'b0;
      ctrl_q <= dtvc_pkg::CTRL_RESET;
    end else begin
      avsWaitRequest <= 1'b1;
      avsReadDataValid <= 1'b0;
      busy_q <= 1'b0;
      if ((avsRead || avsWrite) && !busy_q) begin
        busy_q <= 1'b1;
        avsWaitRequest <= 1'b0;
        avsResponse <= !hit;
        if (avsRead) begin
          avsReadDataValid <= 1'b1;
          case (32'(avsAddress))
            dtvc_pkg::CSR_CTRL: avsReadData <= ctrl_q;
            dtvc_pkg::CSR_STATUS: avsReadData <= {26'h0, lastErr_q,
              fifoOutValid, !fifoInReady, state_q == dtvc_pkg::ST_IDLE,
              traceValid, enable};
            dtvc_pkg::CSR_COUNT: avsReadData <= {errCount_q[15:0],
                                                 pktCount_q[15:0]};
            default: avsReadData <= 32'h0;
          endcase
        end
      end
      if (avsWrite && !avsWaitRequest &&
          32'(avsAddress) == dtvc_pkg::CSR_CTRL && avsByteEnable[0]) begin
        ctrl_q <= {31'h0, avsWriteData[0]};
      end
    end
  end
endmodule
`default_nettype wire

// [core/dtvc_pkg.sv]
package dtvc_pkg;
  localparam logic [4:0] F5_HDR_TOP = 5'h03;
  localparam logic [4:0] F6_HDR_TOP = 5'h07;
  localparam logic [7:0] IGNORE_BYTE = 8'h05;
  localparam logic [7:0] EVENT_BYTE = 8'h04;
  localparam logic [2:0] KEY_CODE_RESERVED = 3'h7;
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int CSR_CTRL = 32'h0000_0000;
  localparam int CSR_STATUS = 32'h0000_0004;
  localparam int CSR_COUNT = 32'h0000_0008;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_HDR = 4'h2,
    ST_DATA = 4'h4,
    ST_PAD = 4'h8
  } dtvc_state_t;
endpackage

// [core/dtvc_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
// ======================================================
// byte fifo with valid/ready on both sides
module dtvc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk, // clock
  input wire logic srst, // sync reset
  input wire logic inValid, // write offer
  output logic inReady, // not full
  input wire logic [WIDTH-1:0] inData, // write data
  output logic outValid, // not empty
  input wire logic outReady, // read accept
  output logic [WIDTH-1:0] outData // head word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_q;
  logic [AW-1:0] rdPtr_q;
  logic [AW:0] cnt_q;
  logic doWr;
  logic doRd;
  // full and empty come from the occupancy count, not the pointers
  assign inReady = (cnt_q != (AW+1)'(DEPTH));
  assign outValid = (cnt_q != '0);
  assign outData = mem[rdPtr_q];
  assign doWr = inValid && inReady;
  assign doRd = outValid && outReady;
  // storage has no reset; contents are qualified by the count
  always_ff @(posedge sys_clk) begin
    if (doWr) begin
      mem[wrPtr_q] <= inData;
    end
  end
  // pointers and count
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      cnt_q <= '0;
    end else begin
      if (doWr) begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (doRd) begin
        rdPtr_q <= rdPtr_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(doWr) - (AW+1)'(doRd);
    end
  end
endmodule
`default_nettype wire

// [testbench/dtvc_coder_checker.sv]
`timescale 1ns/1ps
`default_nettype none
// ======================================================
// port-level checks on the value packet coder
module dtvc_coder_checker (
  input wire logic sys_clk, // clock
  input wire logic srst, // sync reset
  input wire logic reqValid, // request offered
  input wire logic reqReady, // request taken
  input wire logic [1:0] reqKind, // request kind
  input wire logic reqWide, // eight byte value
  input wire logic [2:0] reqAddrCount, // address elements
  input wire logic traceValid, // byte offered
  input wire logic traceReady, // sink accepts
  input wire logic [7:0] traceData, // trace byte
  input wire logic [3:0] avsAddress, // bus address
  input wire logic avsRead, // bus read
  input wire logic avsWrite, // bus write
  input wire logic avsWaitRequest, // bus stall
  input wire logic avsReadDataValid, // read strobe
  input wire logic avsResponse // unmapped flag
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  // bus cycle steps: pending request, then its answer
  sequence avsAsk;
    (avsRead || avsWrite) && avsWaitRequest;
  endsequence
  sequence avsDone;
    (avsRead || avsWrite) && !avsWaitRequest;
  endsequence
  // a nine byte packet keeps the request side shut while it is pushed
  sequence wideTaken;
    reqReady && reqKind == 2'h0 && reqWide && reqAddrCount inside {[1:4]};
  endsequence
  reqPulse_a: assert property (reqReady |=> !reqReady)
    else $error("request accept wider than one cycle");
  reqCause_a: assert property (reqReady |-> $past(reqValid))
    else $error("request accepted without an offer");
  wideGap_a: assert property (wideTaken |=> !reqReady [*8])
    else $error("request taken while a wide packet streams");
  traceHold_a: assert property (traceValid && !traceReady |=>
    traceValid && $stable(traceData))
    else $error("trace byte changed before it was taken");
  avsAnswer_a: assert property (avsAsk |=> !avsWaitRequest)
    else $error("bus request not answered next cycle");
  avsOneShot_a: assert property (!avsWaitRequest |=> avsWaitRequest)
    else $error("bus answer held over one cycle");
  rdStrobe_a: assert property (avsDone and avsRead |-> avsReadDataValid)
    else $error("read answered without data strobe");
  unmapped_a: assert property (avsDone and
    !(avsAddress inside {4'h0, 4'h4, 4'h8}) |-> avsResponse)
    else $error("unmapped access not flagged");
endmodule
bind dtvc_coder dtvc_coder_checker chk (.sys_clk, .srst, .reqValid,
  .reqReady, .reqKind, .reqWide, .reqAddrCount, .traceValid, .traceReady,
  .traceData, .avsAddress, .avsRead, .avsWrite, .avsWaitRequest,
  .avsReadDataValid, .avsResponse);
`default_nettype wire

// [testbench/dtvc_trace_sink.sv]
`timescale 1ns/1ps
`default_nettype none
// ======================================================
// capture store at the far end of the trace stream
module dtvc_trace_sink (
  input wire logic sys_clk, // clock
  input wire logic srst, // sync reset
  input wire logic traceValid, // byte offered
  input wire logic [7:0] traceData, // trace byte
  input wire logic stall, // bench asks for a slow sink
  output logic traceReady // accepts a byte
);
  logic [7:0] got[$];
  // raw bytes only: sizes are never guessed from counts
  always @(posedge sys_clk) begin
    traceReady <= !srst && !stall;
    if (!srst && traceValid && traceReady) begin
      got.push_back(traceData); // pad and event kept for the bench
    end
  end
endmodule
`default_nettype wire

// [testbench/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic sys_clk = 1'b0, srst = 1'b1, reqValid = 1'b0, reqWide = 1'b0;
  logic reqReady, traceValid, traceReady, stall = 1'b0;
  logic [1:0] reqKind = 2'h0, reqKeyAdvance = 2'h1;
  logic [2:0] reqAddrCount = 3'h1;
  logic [63:0] reqValue0 = 64'h0;
  logic [31:0] reqValue1 = 32'h0, avsWriteData = 32'h0, avsReadData, rd;
  logic [7:0] traceData, exp[$];
  logic [3:0] avsAddress = 4'h0;
  logic avsRead = 1'b0, avsWrite = 1'b0, avsWaitRequest, avsResponse, rsp;
  logic avsReadDataValid;
  int n_fail = 0, comparisons = 0, cyc = 0;
  localparam logic [63:0] V = 64'hF1E2D3C4B5A69788;
  localparam logic [31:0] W = 32'h0BADCAFE;
  always #5 sys_clk = ~sys_clk;
  dtvc_coder dut (.sys_clk, .srst, .reqValid, .reqReady, .reqKind,
    .reqValue0, .reqValue1, .reqWide, .reqAddrCount, .reqKeyAdvance,
    .traceValid, .traceReady, .traceData, .avsAddress, .avsRead, .avsWrite,
    .avsWriteData, .avsByteEnable(4'hF), .avsReadData, .avsWaitRequest,
    .avsReadDataValid, .avsResponse);
  dtvc_trace_sink sink (.sys_clk, .srst, .traceValid, .traceData, .stall,
    .traceReady);
  // ======================================================
  // shared tasks
  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    comparisons++;
    if (seen !== want) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // a hang counts as a mismatch
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  // only the bench timeout ends a bus wait
  task automatic avs(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    avsAddress <= a;
    avsWrite <= w;
    avsRead <= !w;
    avsWriteData <= d;
    do begin
      @(posedge sys_clk);
    end while (avsWaitRequest !== 1'b0);
    rd = avsReadData;
    rsp = avsResponse;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
  endtask
  task automatic send(input logic [1:0] k, input logic w,
      input logic [2:0] c, input logic [1:0] adv);
    int n;
    n = 0;
    @(posedge sys_clk);
    {reqKind, reqWide, reqAddrCount, reqKeyAdvance} <= {k, w, c, adv};
    {reqValue0, reqValue1, reqValid} <= {V, W, 1'b1};
    do begin
      @(posedge sys_clk);
      n++;
    end while (reqReady !== 1'b1 && n < 200);
    reqValid <= 1'b0;
  endtask
  // queue a value's low bytes, least significant first
  task automatic want(input logic [63:0] v, input int nb);
    for (int i = 0; i < nb; i++) exp.push_back(v[8*i +: 8]);
  endtask
  // wait for the expected byte count, then compare the stream
  task automatic drain();
    int n;
    n = 0;
    while (sink.got.size() < exp.size() && n < 500) begin
      @(posedge sys_clk);
      n++;
    end
    repeat (5) @(posedge sys_clk);
    check(sink.got.size(), exp.size());
    foreach (exp[i]) check(sink.got[i], exp[i]);
    exp.delete();
    sink.got.delete();
  endtask
  // ======================================================
  // scenarios
  task automatic t_regs();
    avs(1'b0, 4'h0, 32'h0);
    check(rd, dtvc_pkg::CTRL_RESET);
    avs(1'b0, 4'hC, 32'h0);
    check({rsp, rd}, 33'h1_0000_0000);
    avs(1'b1, 4'h0, 32'h0);
    @(posedge sys_clk);
    reqKind <= 2'h2;
    reqValid <= 1'b1;
    // disabled coder must leave the offer hanging
    repeat (20) begin
      @(posedge sys_clk);
      check(reqReady, 1'b0);
    end
    reqValid <= 1'b0;
    avs(1'b1, 4'h0, 32'h1);
    drain();
  endtask
  task automatic t_f5();
    for (int c = 1; c <= 4; c++) begin
      for (int w = 0; w < 2; w++) begin
        send(2'h0, w[0], c[2:0], 2'h1);
        exp.push_back({dtvc_pkg::F5_HDR_TOP, w[0], 2'(c - 1)});
        want(V, w ? 8 : 4);
      end
    end
    drain();
  endtask
  task automatic t_f6();
    // codes 0..4 are advance one, 5 and 6 advance two and three
    for (int i = 0; i < 7; i++) begin
      send(2'h1, 1'b0, i < 5 ? 3'(i) : 3'h0, i < 5 ? 2'h1 : 2'(i - 3));
      exp.push_back({dtvc_pkg::F6_HDR_TOP, 3'(i)});
      want(V, 4);
      want(W, 4);
    end
    send(2'h1, 1'b0, 3'h2, 2'h2);
    exp.push_back({dtvc_pkg::F5_HDR_TOP, 3'h1});
    want(V, 4);
    send(2'h3, 1'b0, 3'h1, 2'h1);
    send(2'h2, 1'b0, 3'h1, 2'h1);
    exp.push_back(dtvc_pkg::IGNORE_BYTE);
    exp.push_back(dtvc_pkg::EVENT_BYTE);
    send(2'h0, 1'b0, 3'h0, 2'h1);
    drain();
    avs(1'b0, 4'h8, 32'h0);
    check(rd[31:16], 16'h0001);
    avs(1'b0, 4'h4, 32'h0);
    check(rd[5], 1'b1);
  endtask
  task automatic t_full();
    stall <= 1'b1;
    send(2'h1, 1'b0, 3'h4, 2'h1);
    send(2'h1, 1'b0, 3'h3, 2'h1);
    repeat (30) @(posedge sys_clk);
    avs(1'b0, 4'h4, 32'h0);
    check(rd[3], 1'b1);
    stall <= 1'b0;
    for (int i = 4; i > 2; i--) begin
      exp.push_back({dtvc_pkg::F6_HDR_TOP, 3'(i)});
      want(V, 4);
      want(W, 4);
    end
    drain();
  endtask
  initial begin
    repeat (10) @(posedge sys_clk);
    srst <= 1'b0;
    t_regs();
    t_f5();
    t_f6();
    t_full();
    tally_and_finish();
  end
endmodule
`default_nettype wire
